//--- verilog/ftm_fsk_tone_modulator.sv
// fsk tone modulator: gated mark/space dividers, xor combine, divide-by-160 tone stage
//
// Functional notes
// R1 - mark divider runs at 160 times the mark tone, 352 kHz.
// R2 - space divider runs at 160 times the space tone, 192 kHz.
// R3 - mark divider counts only while the data bit is high.
// R4 - space divider counts only while the data bit is low.
// R5 - a stopped divider holds its output level constant.
// R6 - both divider outputs are combined by exclusive-or.
// R7 - output divider divides the combined clock by 160 to form the tone.
// R8 - output divider never restarts on a data change, keeping phase continuous.
// R9 - low-harmonic mode uses a dead band of one third per half wave.
// R10 - dead-band mode drives two outputs, one inverted, summed into three levels.
// R11 - the combined oversample clock is buffered out as the filter clock.
// R12 - filter clock is four times filter sample rate, 40 samples per tone.
// R13 - data source presents serial bits at the baud rate.
// R14 - controlling party starts and stops output through the run input.
// R15 - reset clears all divider counters and holds their outputs low.
`timescale 1ns/1ns
module ftm_fsk_tone_modulator
(
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic srst,
  input wire logic data_in,
  input wire logic deadband_mode,
  input wire logic run,
  output ftm_pkg::ftm_out_type modulator_out
);

  // ----------------------------------------------------------------------
  // data input synchroniser
  // ----------------------------------------------------------------------
  logic [2:0] data_sync;
  logic data_bit;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      data_sync <= ftm_pkg::SYNC_RESET;
    end
    else if (clock_enable)
    begin
      data_sync <= {data_sync[1:0], data_in};
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      data_bit <= 1'b0;
    end
    else if (clock_enable && (data_sync[1] == data_sync[2]))
    begin
      data_bit <= data_sync[2];
    end
  end

  // ----------------------------------------------------------------------
  // mark and space rate dividers
  // ----------------------------------------------------------------------
  logic mark_square;
  logic space_square;
  logic space_run;

  assign space_run = ~data_bit; // R4

  // R1 R3 R5 R15
  ftm_rate_divider #(
    .DIV_CYCLES(ftm_pkg::MARK_DIV_CYCLES)
  ) mark_rate_divider (
    .clock(clock),
    .clock_enable(clock_enable),
    .srst(srst),
    .run(data_bit),
    .square(mark_square)
  );

  // R2 R4 R5 R15
  ftm_rate_divider #(
    .DIV_CYCLES(ftm_pkg::SPACE_DIV_CYCLES)
  ) space_rate_divider (
    .clock(clock),
    .clock_enable(clock_enable),
    .srst(srst),
    .run(space_run),
    .square(space_square)
  );

  // ----------------------------------------------------------------------
  // combined oversample clock and its buffered copy
  // ----------------------------------------------------------------------
  logic combined_clock;
  logic combined_prev;
  logic combined_rise;

  // the held divider only flips the polarity of the running one
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      combined_clock <= 1'b0;
      combined_prev <= 1'b0;
    end
    else if (clock_enable)
    begin
      combined_clock <= mark_square ^ space_square; // R6 R11
      combined_prev <= combined_clock;
    end
  end

  assign combined_rise = combined_clock & ~combined_prev;

  // ----------------------------------------------------------------------
  // output tone divider
  // ----------------------------------------------------------------------
  logic [7:0] tone_count;
  logic [7:0] next_tone_count;

  always_comb
  begin
    next_tone_count = tone_count;
    if (combined_rise)
    begin
      if (tone_count == ftm_pkg::TONE_LAST)
      begin
        next_tone_count = ftm_pkg::TONE_COUNT_RESET;
      end
      else
      begin
        next_tone_count = tone_count + 8'h01;
      end
    end
  end

  // no clear on a data change: the tone simply continues at the new rate,
  // so the phase step is at most one oversample period
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      tone_count <= ftm_pkg::TONE_COUNT_RESET; // R15
    end
    else if (clock_enable)
    begin
      tone_count <= next_tone_count; // R7 R8
    end
  end

  // ----------------------------------------------------------------------
  // filter sample phase
  // ----------------------------------------------------------------------
  logic [1:0] filter_phase;
  logic next_sample_strobe;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      filter_phase <= ftm_pkg::FILTER_PHASE_RESET;
    end
    else if (clock_enable && combined_rise)
    begin
      filter_phase <= filter_phase + 2'h1; // R12
    end
  end

  assign next_sample_strobe = combined_rise && (filter_phase == ftm_pkg::FILTER_PHASE_LAST);

  // ----------------------------------------------------------------------
  // square and dead-band output shaping
  // ----------------------------------------------------------------------
  logic first_half;
  logic in_active;
  logic [7:0] half_pos;
  logic next_tone;
  logic next_drive_pos;
  logic next_drive_neg_n;

  always_comb
  begin
    first_half = (next_tone_count < ftm_pkg::TONE_HALF);
    if (first_half)
    begin
      half_pos = next_tone_count;
    end
    else
    begin
      half_pos = next_tone_count - ftm_pkg::TONE_HALF;
    end
    in_active = (half_pos >= ftm_pkg::ACTIVE_START) && (half_pos < ftm_pkg::ACTIVE_END); // R9
    next_tone = first_half;
    if (!run)
    begin
      // stopped: both drives settle at the midpoint level
      next_tone = 1'b0;
      next_drive_pos = 1'b0; // R14
      next_drive_neg_n = 1'b1;
    end
    else if (deadband_mode)
    begin
      // both high = top rail, pos low + neg_n high = midpoint, both low = bottom
      next_drive_pos = first_half && in_active; // R10
      next_drive_neg_n = ~(!first_half && in_active); // R10
    end
    else
    begin
      next_drive_pos = first_half;
      next_drive_neg_n = first_half;
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      modulator_out <= '0; // R15
    end
    else if (clock_enable)
    begin
      modulator_out.tone <= next_tone;
      modulator_out.drive_pos <= next_drive_pos;
      modulator_out.drive_neg_n <= next_drive_neg_n;
      modulator_out.filter_clock <= combined_clock; // R11
      modulator_out.sample_strobe <= next_sample_strobe; // R12
    end
  end

endmodule

//--- inc/ftm_pkg.sv
// constants and carrier types for the fsk tone modulator
package ftm_pkg;

  // ----------------------------------------------------------------------
  // clock and tone plan
  // ----------------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 125_000_000;
  localparam int unsigned MARK_TONE_HZ = 2200;
  localparam int unsigned SPACE_TONE_HZ = 1200;
  localparam int unsigned OVERSAMPLE = 160;
  localparam int unsigned MARK_RATE_HZ = OVERSAMPLE * MARK_TONE_HZ;
  localparam int unsigned SPACE_RATE_HZ = OVERSAMPLE * SPACE_TONE_HZ;
  // whole cycles of the source clock per oversample period (rounded down)
  localparam int unsigned MARK_DIV_CYCLES = CLOCK_HZ / MARK_RATE_HZ;
  localparam int unsigned SPACE_DIV_CYCLES = CLOCK_HZ / SPACE_RATE_HZ;

  // ----------------------------------------------------------------------
  // output divider and dead band
  // ----------------------------------------------------------------------
  localparam int unsigned TONE_COUNT_WIDTH = 8;
  localparam logic [7:0] TONE_LAST = 8'(OVERSAMPLE - 1);
  localparam logic [7:0] TONE_HALF = 8'(OVERSAMPLE / 2);
  localparam int unsigned DEADBAND_COUNTS = OVERSAMPLE / 2 / 3;
  // dead band split evenly around each edge of the half wave
  localparam logic [7:0] ACTIVE_START = 8'(DEADBAND_COUNTS / 2);
  localparam logic [7:0] ACTIVE_END = 8'(OVERSAMPLE / 2 - (DEADBAND_COUNTS - DEADBAND_COUNTS / 2));

  // ----------------------------------------------------------------------
  // filter clock and input synchroniser
  // ----------------------------------------------------------------------
  localparam int unsigned FILTER_CLOCK_RATIO = 4;
  localparam logic [1:0] FILTER_PHASE_LAST = 2'(FILTER_CLOCK_RATIO - 1);
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  localparam logic [7:0] TONE_COUNT_RESET = 8'h00;
  localparam logic [1:0] FILTER_PHASE_RESET = 2'h0;

  typedef struct packed {
    logic tone;
    logic drive_pos;
    logic drive_neg_n;
    logic filter_clock;
    logic sample_strobe;
  } ftm_out_type;

endpackage

//--- verilog/ftm_rate_divider.sv
// gated rate divider producing a square wave at clock / div_cycles
`timescale 1ns/1ns
module ftm_rate_divider
#(
  parameter int unsigned DIV_CYCLES = 355
)
(
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic srst,
  input wire logic run,
  output logic square
);

  localparam int unsigned WIDTH = $clog2(DIV_CYCLES);
  localparam logic [WIDTH-1:0] LAST = WIDTH'(DIV_CYCLES - 1);
  localparam logic [WIDTH-1:0] HALF = WIDTH'(DIV_CYCLES / 2);
  localparam logic [WIDTH-1:0] COUNT_RESET = '0;

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb
  begin
    if (count == LAST)
    begin
      next_count = COUNT_RESET;
    end
    else
    begin
      next_count = count + WIDTH'(1);
    end
  end

  // count and output freeze while stopped, so the output holds its level
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      count <= COUNT_RESET;
      square <= 1'b0;
    end
    else if (clock_enable && run)
    begin
      count <= next_count;
      square <= (next_count < HALF);
    end
  end

endmodule

//--- dv/ftm_props.sv
// concurrent checks on the fsk tone modulator ports
`timescale 1ns/1ns
module ftm_props
(
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic srst,
  input wire logic data_in,
  input wire logic deadband_mode,
  input wire logic run,
  input wire ftm_pkg::ftm_out_type modulator_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ----
  // properties
  // ----
  property p_reset_clear;
    @(posedge clock) disable iff (1'b0) srst |=> modulator_out == 5'h00;
  endproperty
  property p_stop;
    clock_enable && !run |=> {modulator_out.tone, modulator_out.drive_pos, modulator_out.drive_neg_n} == 3'h1;
  endproperty
  property p_square;
    clock_enable && run && !deadband_mode |=> modulator_out.drive_pos == modulator_out.tone
      && modulator_out.drive_neg_n == modulator_out.tone;
  endproperty
  property p_pos_high;
    modulator_out.drive_pos |-> modulator_out.tone;
  endproperty
  property p_neg_low;
    !modulator_out.drive_neg_n |-> !modulator_out.tone;
  endproperty
  property p_dead_lead;
    // a tone step caused by run coming back is not a wrap of the tone counter
    $rose(modulator_out.tone) && deadband_mode && $past(deadband_mode) && run && $past(run) && $past(run, 2)
      |-> !modulator_out.drive_pos [*8];
  endproperty
  property p_strobe_pulse;
    modulator_out.sample_strobe && clock_enable |=> !modulator_out.sample_strobe;
  endproperty
  property p_strobe_high;
    modulator_out.sample_strobe |-> modulator_out.filter_clock;
  endproperty
  property p_freeze;
    !clock_enable |=> $stable(modulator_out);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared in reset");
  a_stop: assert property (p_stop) else $error("stopped output not at midpoint");
  a_square: assert property (p_square) else $error("square drive differs from tone");
  a_pos_high: assert property (p_pos_high) else $error("positive drive outside high half");
  a_neg_low: assert property (p_neg_low) else $error("negative drive outside low half");
  a_dead_lead: assert property (p_dead_lead) else $error("no leading dead band");
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one cycle");
  a_strobe_high: assert property (p_strobe_high) else $error("strobe while filter clock low");
  a_freeze: assert property (p_freeze) else $error("outputs moved while stalled");
  c_dead: cover property ($rose(modulator_out.drive_pos) && deadband_mode);
  c_mid: cover property (!run ##1 modulator_out.drive_neg_n);
  c_switch: cover property ($changed(data_in));
endmodule
bind ftm_fsk_tone_modulator ftm_props ftm_props_inst (.clock(clock), .clock_enable(clock_enable), .srst(srst),
  .data_in(data_in), .deadband_mode(deadband_mode), .run(run), .modulator_out(modulator_out));

//--- dv/ftm_data_source.sv
// serial data source: alternating bits each bit period, or a held level
`timescale 1ns/1ns
module ftm_data_source
#(
  parameter int BIT_CYCLES = 104167
)
(
  input wire logic clock,
  input wire logic go,
  input wire logic level,
  output logic data_in
);
  int count = 0;
  // bits move on the falling edge, clear of the sampling edge
  always @(negedge clock)
  begin
    if (!go)
    begin
      data_in <= level;
      count <= 0;
    end
    else if (count == BIT_CYCLES - 1)
    begin
      data_in <= ~data_in;
      count <= 0;
    end
    else
      count <= count + 1;
  end
endmodule

//--- dv/tb.sv
// self-checking bench for the fsk tone modulator
`timescale 1ns/1ns
module tb;
  typedef struct {logic data; int fc_period; int strobe_period;} ftm_row_type;
  logic clock = 1'b0;
  logic clock_enable = 1'b1;
  logic srst = 1'b1;
  logic deadband_mode = 1'b0;
  logic run = 1'b1;
  logic go = 1'b0;
  logic level = 1'b0;
  logic data_in;
  logic p;
  ftm_pkg::ftm_out_type modulator_out;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int a, b, d;
  ftm_row_type rows [2];
  always #4 clock = ~clock;
  ftm_data_source #(.BIT_CYCLES(1500)) ftm_data_source_inst (.clock(clock), .go(go), .level(level),
    .data_in(data_in));
  ftm_fsk_tone_modulator ftm_fsk_tone_modulator_inst (.clock(clock), .clock_enable(clock_enable), .srst(srst),
    .data_in(data_in), .deadband_mode(deadband_mode), .run(run), .modulator_out(modulator_out));
  // ----
  // helpers
  // ----
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic wt(input int s, input logic v, output int n);
    n = 0;
    while (modulator_out[s] !== v)
    begin
      @(negedge clock);
      n++;
    end
  endtask
  // rise to rise, after a first rise to get in step
  task automatic per(input int s, output int n);
    int x, y;
    wt(s, 1'b0, x);
    wt(s, 1'b1, x);
    wt(s, 1'b0, x);
    wt(s, 1'b1, y);
    n = x + y;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 120000)
    begin
      err_count++;
      conclude();
    end
  end
  // ----
  // sequence
  // ----
  initial
  begin
    rows[0] = '{1'b0, ftm_pkg::SPACE_DIV_CYCLES, 4 * ftm_pkg::SPACE_DIV_CYCLES};
    rows[1] = '{1'b1, ftm_pkg::MARK_DIV_CYCLES, 4 * ftm_pkg::MARK_DIV_CYCLES};
    repeat (10) @(negedge clock);
    chk("reset outputs", 5'h00, modulator_out);
    srst = 1'b0;
    go = 1'b1;
    repeat (3500) @(negedge clock);
    go = 1'b0;
    $display("test reset and alternating data done");
    foreach (rows[i])
    begin
      level = rows[i].data;
      repeat (10) @(negedge clock);
      per(1, a);
      chk("filter clock period", rows[i].fc_period, a);
      per(0, a);
      chk("sample strobe period", rows[i].strobe_period, a);
      $display("test row %0d done", i);
    end
    clock_enable = 1'b0;
    repeat (5) @(negedge clock);
    clock_enable = 1'b1;
    run = 1'b0;
    repeat (2) @(negedge clock);
    chk("stopped drive", 3'h1, {modulator_out.tone, modulator_out.drive_pos, modulator_out.drive_neg_n});
    run = 1'b1;
    $display("test stall and stop done");
    // positive plateau on drive_pos, negative on drive_neg_n low: both active at level p
    deadband_mode = 1'b1;
    // let the restart settle so the first tone step seen is a real half-wave edge
    repeat (2) @(negedge clock);
    p = modulator_out.tone;
    wt(4, !p, d);
    p = !p;
    wt(p ? 3 : 2, p, a);
    wt(p ? 3 : 2, !p, b);
    wt(4, !p, d);
    chk("dead band lead", ftm_pkg::ACTIVE_START * ftm_pkg::MARK_DIV_CYCLES, a);
    chk("active plateau", (ftm_pkg::ACTIVE_END - ftm_pkg::ACTIVE_START) * ftm_pkg::MARK_DIV_CYCLES, b);
    chk("tone half", ftm_pkg::OVERSAMPLE / 2 * ftm_pkg::MARK_DIV_CYCLES, a + b + d);
    $display("test dead band done");
    // a restart at the bit change would move this edge by about a quarter tone
    repeat (40 * ftm_pkg::MARK_DIV_CYCLES) @(negedge clock);
    level = 1'b0;
    repeat (100) @(negedge clock);
    level = 1'b1;
    wt(4, p, d);
    // a restart would cut this half short or stretch it by half its length, depending on its level
    a = d + 40 * ftm_pkg::MARK_DIV_CYCLES + 100;
    chk("no restart", 1'b1, a > 78 * ftm_pkg::MARK_DIV_CYCLES && a < 83 * ftm_pkg::MARK_DIV_CYCLES);
    $display("test phase continuity done");
    srst = 1'b1;
    repeat (2) @(negedge clock);
    chk("mid-run reset", 5'h00, modulator_out);
    srst = 1'b0;
    $display("test mid-run reset done");
    conclude();
  end
endmodule
